// *** verilog/exec_unit.sv ***
// Execution unit for add-with-carry, and, bit-clear and conditional branches
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Decode 0010 00da as add acc+carry to file
// - Sum acc, file, carry; update N OV C DC Z
// - Destination bit picks accumulator or file
// - Access bit picks access bank or banked
// - Extended mode, a=0, f<=95: indexed offset
// - 0000 1011 ands literal into acc; N, Z
// - 0001 01da ands acc with file to dest
// - Taken branch target: pc+2+twice signed offset
// - Branch one cycle, taken two; flags kept
// - 1110 0010 branches when carry set
// - 1110 0110 branches when negative set
// - 1110 0011 branches when carry clear
// - 1001 bbba clears one file bit, no flags
module exec_unit (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_instr_valid, // Instruction offered
   input wire logic [15:0] i_instr, // Instruction word
   input wire logic [3:0] i_bsr, // Bank select register contents
   input wire logic i_ext_en, // Extended instruction set enabled
   input wire logic [11:0] i_index_base, // Base for indexed literal offset
   input wire logic [7:0] i_mem_rdata, // File read data, cycle after read
   output logic o_ready, // Unit idle, may take an instruction
   output logic [11:0] o_mem_addr, // File address
   output logic o_mem_rd, // File read strobe
   output logic o_mem_wr, // File write strobe
   output logic [7:0] o_mem_wdata, // File write data
   output logic [7:0] o_acc, // Working accumulator
   output logic [4:0] o_status, // Flags N OV Z DC C
   output logic [20:0] o_pc, // Program counter
   output logic o_done, // Instruction retired
   output logic o_illegal // Word not handled by this unit
);

   // ***************************************************************
   // Helper functions
   // ***************************************************************

   // Data address from access bit, file field and mode
   function automatic logic [11:0] file_addr(input logic a, input logic [7:0] f,
                                             input logic [3:0] bank_select_register, input logic ext,
                                             input logic [11:0] base);
      logic [11:0] r;
      r = {4'h0, f};
      if (a) begin
         r = {bank_select_register, f};
      end else if (ext && (f <= exec_pkg::INDEXED_MAX_F)) begin
         r = base + {4'h0, f};
      end else if (f >= exec_pkg::ACCESS_SPLIT) begin
         r = {exec_pkg::ACCESS_HIGH_BANK, f};
      end
      return r;
   endfunction

   // Replace N and Z of a status word from a result
   function automatic logic [4:0] nz_flags(input logic [4:0] st, input logic [7:0] res);
      logic [4:0] r;
      r = st;
      r[exec_pkg::STAT_N] = res[7];
      r[exec_pkg::STAT_Z] = (res == 8'h00);
      return r;
   endfunction

   // ***************************************************************
   // State
   // ***************************************************************
   exec_pkg::seq_state_t state_reg, state_next; // Phase sequencer
   exec_pkg::op_t op_reg, op_next; // Decoded operation
   logic [15:0] instr_reg, instr_next; // Held instruction word
   logic [11:0] addr_reg, addr_next; // File address
   logic rd_reg, rd_next; // Read strobe
   logic wr_reg, wr_next; // Write strobe
   logic [7:0] wdata_reg, wdata_next; // Write data
   logic [7:0] result_reg, result_next; // Result of process phase
   logic [4:0] flags_new_reg, flags_new_next; // Flags from process phase
   logic taken_reg, taken_next; // Branch condition met
   logic [7:0] acc_reg, acc_next; // Working accumulator
   logic [4:0] status_reg, status_next; // Status flags
   logic [20:0] pc_reg, pc_next; // Program counter
   logic ready_reg, ready_next; // Idle indication
   logic done_reg, done_next; // Retire pulse
   logic illegal_reg, illegal_next; // Unknown word pulse

   // ***************************************************************
   // Decode helpers
   // ***************************************************************
   logic [7:0] hi; // Upper byte of held word
   logic [7:0] lo; // Lower byte: file field, literal or offset
   logic dest_file; // Result goes to the file
   logic [8:0] sum; // Add with carry, ninth bit is carry out
   logic [4:0] nib_sum; // Low nibble sum for digit carry
   logic [20:0] branch_ofs; // Sign extended doubled offset

   assign hi = instr_reg[15:8];
   assign lo = instr_reg[7:0];
   assign dest_file = instr_reg[exec_pkg::DEST_BIT];
   assign sum = {1'b0, acc_reg} + {1'b0, i_mem_rdata}
                + {8'h00, status_reg[exec_pkg::STAT_C]};
   assign nib_sum = {1'b0, acc_reg[3:0]} + {1'b0, i_mem_rdata[3:0]}
                    + {4'h0, status_reg[exec_pkg::STAT_C]};
   assign branch_ofs = {{12{lo[7]}}, lo, 1'b0};

   // ***************************************************************
   // Sequencer: next state and handshake
   // ***************************************************************
   // Phases run one per clock; a taken branch adds four idle phases
   always_comb begin
      state_next = state_reg;
      ready_next = 1'b0;
      done_next = 1'b0;
      case (state_reg)
         exec_pkg::ST_IDLE: begin
            if (i_instr_valid) begin
               state_next = exec_pkg::ST_Q1;
            end else begin
               ready_next = 1'b1;
            end
         end
         exec_pkg::ST_Q1: state_next = exec_pkg::ST_Q2; // Decode
         exec_pkg::ST_Q2: state_next = exec_pkg::ST_Q3; // Read operand
         exec_pkg::ST_Q3: state_next = exec_pkg::ST_Q4; // Process data
         exec_pkg::ST_Q4: begin
            // Write phase; a taken branch needs a second cycle
            if (taken_reg) begin
               state_next = exec_pkg::ST_N1;
            end else begin
               state_next = exec_pkg::ST_IDLE;
               ready_next = 1'b1;
               done_next = 1'b1;
            end
         end
         exec_pkg::ST_N1: state_next = exec_pkg::ST_N2; // No operation
         exec_pkg::ST_N2: state_next = exec_pkg::ST_N3;
         exec_pkg::ST_N3: state_next = exec_pkg::ST_N4;
         exec_pkg::ST_N4: begin
            state_next = exec_pkg::ST_IDLE;
            ready_next = 1'b1;
            done_next = 1'b1;
         end
         default: begin
            // Illegal encoding recovers to idle
            state_next = exec_pkg::ST_IDLE;
            ready_next = 1'b1;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= exec_pkg::ST_IDLE;
         ready_reg <= 1'b1;
         done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         ready_reg <= ready_next;
         done_reg <= done_next;
      end
   end

   // ***************************************************************
   // Data path: decode, operand, result, architectural state
   // ***************************************************************
   // Every phase only touches its own part; pc steps in Q1, acc, flags and any branch target are committed in Q4
   always_comb begin
      instr_next = instr_reg;
      op_next = op_reg;
      addr_next = addr_reg;
      rd_next = 1'b0;
      wr_next = 1'b0;
      wdata_next = wdata_reg;
      result_next = result_reg;
      flags_new_next = flags_new_reg;
      taken_next = taken_reg;
      acc_next = acc_reg;
      status_next = status_reg;
      pc_next = pc_reg;
      illegal_next = 1'b0;
      case (state_reg)
         exec_pkg::ST_IDLE: begin
            // Word taken only while idle
            if (i_instr_valid) begin
               instr_next = i_instr;
            end
         end
         exec_pkg::ST_Q1: begin
            // Decode and step past the fetched word
            taken_next = 1'b0;
            pc_next = pc_reg + exec_pkg::PC_STEP;
            addr_next = file_addr(instr_reg[exec_pkg::ACCESS_BIT], lo, i_bsr,
                                  i_ext_en, i_index_base);
            if (hi[7:2] == exec_pkg::ADD_ACC_CARRY_TO_FILE_OP) begin
               op_next = exec_pkg::OP_ADDC;
            end else if (hi == exec_pkg::AND_LITERAL_INTO_ACC_OP) begin
               op_next = exec_pkg::OP_ANDL;
            end else if (hi[7:2] == exec_pkg::AND_ACC_WITH_FILE_OP) begin
               op_next = exec_pkg::OP_ANDF;
            end else if (hi == exec_pkg::BRANCH_ON_CARRY_SET_OP) begin
               op_next = exec_pkg::OP_BC;
            end else if (hi == exec_pkg::BRANCH_ON_NEGATIVE_OP) begin
               op_next = exec_pkg::OP_BN;
            end else if (hi == exec_pkg::BRANCH_ON_CARRY_CLEAR_OP) begin
               op_next = exec_pkg::OP_BNC;
            end else if (hi[7:4] == exec_pkg::BIT_CLEAR_IN_FILE_OP) begin
               op_next = exec_pkg::OP_BCLR;
            end else begin
               // Not ours: runs as a one cycle no-operation
               op_next = exec_pkg::OP_BAD;
            end
         end
         exec_pkg::ST_Q2: begin
            // Read phase: the file read strobe was raised on entry, see below
            if (op_reg == exec_pkg::OP_BAD) begin
               illegal_next = 1'b1;
            end
         end
         exec_pkg::ST_Q3: begin
            // Process phase, file data arrives now
            flags_new_next = status_reg; // Kept unless the operation sets them
            case (op_reg)
               exec_pkg::OP_ADDC: begin
                  result_next = sum[7:0];
                  flags_new_next = nz_flags(status_reg, sum[7:0]);
                  flags_new_next[exec_pkg::STAT_C] = sum[8];
                  flags_new_next[exec_pkg::STAT_DC] = nib_sum[4];
                  flags_new_next[exec_pkg::STAT_OV] = (acc_reg[7] == i_mem_rdata[7])
                                                      && (sum[7] != acc_reg[7]);
               end
               exec_pkg::OP_ANDL: begin
                  result_next = acc_reg & lo;
                  flags_new_next = nz_flags(status_reg, acc_reg & lo);
               end
               exec_pkg::OP_ANDF: begin
                  result_next = acc_reg & i_mem_rdata;
                  flags_new_next = nz_flags(status_reg, acc_reg & i_mem_rdata);
               end
               exec_pkg::OP_BCLR: begin
                  result_next = i_mem_rdata
                                & ~(8'h01 << instr_reg[exec_pkg::BIT_IDX_LSB +: 3]);
               end
               exec_pkg::OP_BC: taken_next = status_reg[exec_pkg::STAT_C];
               exec_pkg::OP_BN: taken_next = status_reg[exec_pkg::STAT_N];
               exec_pkg::OP_BNC: taken_next = !status_reg[exec_pkg::STAT_C];
               default: result_next = result_reg;
            endcase
            // Write strobe prepared for the write phase
            if ((op_reg == exec_pkg::OP_BCLR) ||
                (dest_file && ((op_reg == exec_pkg::OP_ADDC) ||
                               (op_reg == exec_pkg::OP_ANDF)))) begin
               wr_next = 1'b1;
               wdata_next = result_next; // Same value the result register takes
            end
         end
         exec_pkg::ST_Q4: begin
            // Write phase
            status_next = flags_new_reg;
            if ((op_reg == exec_pkg::OP_ANDL) ||
                (!dest_file && ((op_reg == exec_pkg::OP_ADDC) ||
                                (op_reg == exec_pkg::OP_ANDF)))) begin
               acc_next = result_reg;
            end
            if (taken_reg) begin
               pc_next = pc_reg + branch_ofs;
            end
         end
         default: begin
            // No-operation phases change nothing
         end
      endcase
      // Read strobe issued on entry to the read phase
      if ((state_reg == exec_pkg::ST_Q1) &&
          ((hi[7:2] == exec_pkg::ADD_ACC_CARRY_TO_FILE_OP) ||
           (hi[7:2] == exec_pkg::AND_ACC_WITH_FILE_OP) ||
           (hi[7:4] == exec_pkg::BIT_CLEAR_IN_FILE_OP))) begin
         rd_next = 1'b1;
      end
   end

   // Data path registers
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         instr_reg <= 16'h0000;
         op_reg <= exec_pkg::OP_BAD;
         addr_reg <= 12'h000;
         rd_reg <= 1'b0;
         wr_reg <= 1'b0;
         wdata_reg <= 8'h00;
         result_reg <= 8'h00;
         flags_new_reg <= exec_pkg::STATUS_RST;
         taken_reg <= 1'b0;
         acc_reg <= exec_pkg::ACC_RST;
         status_reg <= exec_pkg::STATUS_RST;
         pc_reg <= exec_pkg::PC_RST;
         illegal_reg <= 1'b0;
      end else begin
         instr_reg <= instr_next;
         op_reg <= op_next;
         addr_reg <= addr_next;
         rd_reg <= rd_next;
         wr_reg <= wr_next;
         wdata_reg <= wdata_next;
         result_reg <= result_next;
         flags_new_reg <= flags_new_next;
         taken_reg <= taken_next;
         acc_reg <= acc_next;
         status_reg <= status_next;
         pc_reg <= pc_next;
         illegal_reg <= illegal_next;
      end
   end

   // ***************************************************************
   // Outputs, all straight from flip-flops
   // ***************************************************************
   assign o_ready = ready_reg;
   assign o_mem_addr = addr_reg;
   assign o_mem_rd = rd_reg;
   assign o_mem_wr = wr_reg;
   assign o_mem_wdata = wdata_reg;
   assign o_acc = acc_reg;
   assign o_status = status_reg;
   assign o_pc = pc_reg;
   assign o_done = done_reg;
   assign o_illegal = illegal_reg;

endmodule

`default_nettype wire

// *** verilog/exec_pkg.sv ***
// Shared constants and types for the add, and, bit-clear and branch execution unit
package exec_pkg;

   // ***************************************************************
   // Widths
   // ***************************************************************
   localparam int unsigned DATA_W = 8; // Data path width
   localparam int unsigned ADDR_W = 12; // Data memory address width
   localparam int unsigned PC_W = 21; // Program counter width

   // ***************************************************************
   // Opcode patterns on the upper byte of the instruction word
   // ***************************************************************
   localparam logic [5:0] ADD_ACC_CARRY_TO_FILE_OP = 6'h08; // 0010 00da
   localparam logic [7:0] AND_LITERAL_INTO_ACC_OP = 8'h0b; // 0000 1011
   localparam logic [5:0] AND_ACC_WITH_FILE_OP = 6'h05; // 0001 01da
   localparam logic [7:0] BRANCH_ON_CARRY_SET_OP = 8'he2; // 1110 0010
   localparam logic [7:0] BRANCH_ON_NEGATIVE_OP = 8'he6; // 1110 0110
   localparam logic [7:0] BRANCH_ON_CARRY_CLEAR_OP = 8'he3; // 1110 0011
   localparam logic [3:0] BIT_CLEAR_IN_FILE_OP = 4'h9; // 1001 bbba

   // ***************************************************************
   // Instruction field positions
   // ***************************************************************
   localparam int unsigned DEST_BIT = 9; // d: 0 to accumulator, 1 to file
   localparam int unsigned ACCESS_BIT = 8; // a: 0 access bank, 1 banked
   localparam int unsigned BIT_IDX_LSB = 9; // bbb field of bit clear

   // ***************************************************************
   // Addressing constants
   // ***************************************************************
   localparam logic [7:0] INDEXED_MAX_F = 8'h5f; // Highest f using indexed offset
   localparam logic [7:0] ACCESS_SPLIT = 8'h60; // Access bank low/high split
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf; // Bank of upper access half

   // ***************************************************************
   // Status register layout and reset values
   // ***************************************************************
   localparam int unsigned STAT_C = 0; // Carry
   localparam int unsigned STAT_DC = 1; // Digit carry
   localparam int unsigned STAT_Z = 2; // Zero
   localparam int unsigned STAT_OV = 3; // Overflow
   localparam int unsigned STAT_N = 4; // Negative
   localparam logic [4:0] STATUS_RST = 5'h00; // Flags after reset
   localparam logic [7:0] ACC_RST = 8'h00; // Accumulator after reset
   localparam logic [20:0] PC_RST = 21'h000000; // Program counter after reset
   localparam logic [20:0] PC_STEP = 21'h000002; // Bytes per instruction word

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_Q1 = 9'h002,
      ST_Q2 = 9'h004,
      ST_Q3 = 9'h008,
      ST_Q4 = 9'h010,
      ST_N1 = 9'h020,
      ST_N2 = 9'h040,
      ST_N3 = 9'h080,
      ST_N4 = 9'h100
   } seq_state_t;

   typedef enum logic [2:0] {
      OP_ADDC = 3'h0,
      OP_ANDL = 3'h1,
      OP_ANDF = 3'h2,
      OP_BC = 3'h3,
      OP_BN = 3'h4,
      OP_BNC = 3'h5,
      OP_BCLR = 3'h6,
      OP_BAD = 3'h7
   } op_t;

endpackage

// *** dv/exec_unit_chk.sv ***
// Port timing checker for the execution unit
`timescale 1ns/1ps
`default_nettype none
module exec_unit_chk (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_instr_valid,
   input wire logic [15:0] i_instr,
   input wire logic o_ready,
   input wire logic o_mem_rd,
   input wire logic o_mem_wr,
   input wire logic [7:0] o_acc,
   input wire logic [4:0] o_status,
   input wire logic [20:0] o_pc,
   input wire logic o_done
);
   // ****
   // Decode of the offered word
   // ****
   logic [7:0] op; // Opcode byte
   logic [7:0] lit; // Literal or offset byte
   logic [20:0] tgt; // Target if the branch is taken
   logic tk, jmp, fil, wrf, andl, andf, keep;
   // Branch outcome uses flags standing before the word
   always_comb begin
      op = i_instr[15:8];
      lit = i_instr[7:0];
      tk = i_instr_valid && o_ready;
      jmp = (op == 8'he2 && o_status[0]) || (op == 8'he6 && o_status[4]);
      jmp = jmp || (op == 8'he3 && !o_status[0]);
      andl = op == 8'h0b;
      andf = op[7:2] == 6'h05;
      fil = op[7:2] == 6'h08 || andf || op[7:4] == 4'h9;
      wrf = fil && (op[1] || op[7:4] == 4'h9);
      keep = op[7:4] == 4'h9 || op == 8'he2 || op == 8'he6 || op == 8'he3;
      tgt = o_pc + 21'h000002 + {{12{lit[7]}}, lit, 1'b0};
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_take;
      tk;
   endsequence
   sequence s_rd_pulse;
      !o_mem_rd ##1 o_mem_rd ##1 !o_mem_rd;
   endsequence
   // ****
   // Properties
   // ****
   a_alu_done_time: assert property (s_take ##0 !jmp |-> ##1 !o_done [*4] ##1 o_done)
      else $error("done not in fifth cycle");
   a_jump_done_time: assert property (s_take ##0 jmp |-> ##1 !o_done [*8] ##1 o_done)
      else $error("taken branch not two cycles");
   a_read_in_q2: assert property (s_take ##0 fil |-> ##1 s_rd_pulse)
      else $error("file read not in second quarter");
   a_write_in_q4: assert property (s_take ##0 wrf |-> ##1 !o_mem_wr [*3] ##1 o_mem_wr)
      else $error("file write not in fourth quarter");
   a_no_file_write: assert property (s_take ##0 !wrf |-> ##1 !o_mem_wr [*5])
      else $error("unexpected file write");
   a_flags_kept: assert property (s_take ##0 keep |-> ##5 o_status == $past(o_status, 5))
      else $error("flags changed");
   a_and_flags: assert property (s_take ##0 (andl || andf) |->
      ##5 (o_status & 5'h0b) == ($past(o_status, 5) & 5'h0b))
      else $error("and touched other flags");
   a_literal_and: assert property (s_take ##0 andl |-> ##5 o_acc == ($past(o_acc, 5) & $past(lit, 5))
      && o_status[2] == (o_acc == 8'h00) && o_status[4] == o_acc[7])
      else $error("literal and result wrong");
   a_pc_step: assert property (s_take ##0 !jmp |-> ##5 o_pc == $past(o_pc, 5) + 21'h000002)
      else $error("pc not advanced by one word");
   a_pc_target: assert property (s_take ##0 jmp |-> ##9 o_pc == $past(tgt, 9))
      else $error("branch target wrong");
   a_busy_ready: assert property (s_take |-> ##1 !o_ready [*4])
      else $error("ready during execution");
endmodule
bind exec_unit exec_unit_chk u_exec_unit_chk (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
   .i_instr_valid(i_instr_valid), .i_instr(i_instr), .o_ready(o_ready), .o_mem_rd(o_mem_rd),
   .o_mem_wr(o_mem_wr), .o_acc(o_acc), .o_status(o_status), .o_pc(o_pc), .o_done(o_done));
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking testbench for the execution unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic i_core_clk = 1'b0;
   logic i_rst_n, i_instr_valid, i_ext_en;
   logic [15:0] i_instr;
   logic [3:0] i_bsr;
   logic [11:0] i_index_base;
   logic [7:0] i_mem_rdata = 8'h00; // File read data from the memory model
   logic o_ready, o_mem_rd, o_mem_wr, o_done, o_illegal;
   logic [11:0] o_mem_addr;
   logic [7:0] o_mem_wdata, o_acc;
   logic [4:0] o_status;
   logic [20:0] o_pc;
   int fails = 0; // Mismatches
   int check_count = 0; // Comparisons
   int wr_n = 0; // Writes seen
   int ill_n = 0; // Unknown-word pulses seen
   logic [7:0] mem [0:4095]; // File memory model
   logic rd_q = 1'b0; // Read strobe seen last cycle
   logic [11:0] addr_q, wr_a; // Read address, last write address
   logic [7:0] wr_d, m_acc; // Last write data, expected accumulator
   logic [4:0] m_st; // Expected flags {N,OV,Z,DC,C}
   logic [20:0] m_pc; // Expected program counter
   exec_unit u_exec_unit (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
      .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_bsr(i_bsr), .i_ext_en(i_ext_en),
      .i_index_base(i_index_base), .i_mem_rdata(i_mem_rdata), .o_ready(o_ready),
      .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
      .o_mem_wdata(o_mem_wdata), .o_acc(o_acc), .o_status(o_status), .o_pc(o_pc),
      .o_done(o_done), .o_illegal(o_illegal));
   always #5 i_core_clk = ~i_core_clk;
   // Memory answers the cycle after a read; otherwise the bus toggles so stale data never matches
   always @(posedge i_core_clk) begin
      #1;
      i_mem_rdata = rd_q ? mem[addr_q] : ~i_mem_rdata;
      rd_q = o_mem_rd;
      addr_q = o_mem_addr;
      if (o_illegal === 1'b1) begin
         ill_n++;
      end
      if (o_mem_wr === 1'b1) begin
         wr_n++;
         wr_a = o_mem_addr;
         wr_d = o_mem_wdata;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      if (fails == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ****
   // One instruction: predict, run, compare
   // ****
   task automatic step(input logic [15:0] w);
      logic [7:0] op, f, v, r;
      logic [11:0] a;
      logic [8:0] s;
      logic jmp, wf, alu, bad;
      int n, w0, i0;
      op = w[15:8];
      f = w[7:0];
      a = op[0] ? {i_bsr, f} : (i_ext_en && f <= 8'h5f) ? i_index_base + {4'h0, f} :
         (f < 8'h60) ? {4'h0, f} : {4'hf, f};
      v = mem[a];
      r = m_acc;
      wf = 1'b0;
      jmp = 1'b0;
      alu = op[7:2] == 6'h08 || op == 8'h0b || op[7:2] == 6'h05;
      bad = !alu && op[7:4] != 4'h9 && op != 8'he2 && op != 8'he6 && op != 8'he3;
      if (op[7:2] == 6'h08) begin // Sum with carry in
         s = {1'b0, m_acc} + {1'b0, v} + {8'h00, m_st[0]};
         r = s[7:0];
         m_st[1] = ({1'b0, m_acc[3:0]} + {1'b0, v[3:0]} + {4'h0, m_st[0]}) > 5'h0f;
         m_st[3] = (m_acc[7] == v[7]) && (r[7] != m_acc[7]);
         m_st[0] = s[8];
         wf = op[1];
      end else if (op == 8'h0b) begin
         r = m_acc & f;
      end else if (op[7:2] == 6'h05) begin
         r = m_acc & v;
         wf = op[1];
      end else if (op[7:4] == 4'h9) begin
         r = v & ~(8'h01 << op[3:1]);
         wf = 1'b1;
      end else begin
         jmp = (op == 8'he2 && m_st[0]) || (op == 8'he6 && m_st[4]) || (op == 8'he3 && !m_st[0]);
      end
      if (alu) begin
         m_st[4] = r[7];
         m_st[2] = r == 8'h00;
      end
      if (alu && !wf) m_acc = r;
      m_pc = m_pc + 21'h000002 + (jmp ? {{12{f[7]}}, f, 1'b0} : 21'h000000);
      w0 = wr_n;
      i0 = ill_n;
      i_instr = w;
      i_instr_valid = 1'b1;
      @(posedge i_core_clk);
      #1;
      i_instr_valid = 1'b0;
      n = 1;
      while (o_done !== 1'b1 && n < 20) begin
         @(posedge i_core_clk);
         #1;
         n++;
      end
      if (wf) mem[a] = r;
      chk(n, jmp ? 9 : 5);
      chk(o_acc, m_acc);
      chk(o_status, m_st);
      chk(o_pc, m_pc);
      chk(wr_n - w0, wf);
      chk(ill_n - i0, bad);
      if (wf) begin
         chk(wr_a, a);
         chk(wr_d, r);
      end
   endtask
   // ****
   // Main sequence
   // ****
   initial begin
      i_rst_n = 1'b0;
      i_instr_valid = 1'b0;
      i_instr = 16'h0000;
      i_bsr = 4'h3;
      i_ext_en = 1'b0;
      i_index_base = 12'h200;
      m_acc = 8'h00;
      m_st = 5'h00;
      m_pc = 21'h000000;
      foreach (mem[i]) mem[i] = 8'hff;
      mem[12'h010] = 8'h4d;
      mem[12'h320] = 8'hb3;
      mem[12'hf80] = 8'h02;
      mem[12'h011] = 8'h7f;
      mem[12'h030] = 8'hf0;
      mem[12'h350] = 8'h3c;
      mem[12'h040] = 8'hc7;
      mem[12'hf60] = 8'h80;
      repeat (4) @(posedge i_core_clk);
      #1;
      i_rst_n = 1'b1;
      step(16'h2010);
      step(16'he205);
      step(16'he601);
      step(16'h2320);
      step(16'he304);
      step(16'h2080);
      step(16'h0b5f);
      step(16'h2011);
      step(16'he6fe);
      step(16'he37f);
      step(16'h1430);
      step(16'h1750);
      step(16'h9e40);
      i_ext_en = 1'b1;
      step(16'h905f);
      step(16'h2060);
      step(16'he280);
      step(16'hffff);
      step(16'h0b00);
      complete_run();
   end
   // Whole run is about 105 cycles
   initial begin
      #20000;
      fails++;
      $display("[ERR] %0t run did not finish", $time);
      complete_run();
   end
endmodule
`default_nettype wire
